//--- rtl/fcm_consts.svh
// register offsets, field positions, reset values and counts of the cipher mode block
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

`define FCM_CTRL_OFS       8'h00
`define FCM_STATUS_OFS     8'h04
`define FCM_KEY_LO_OFS     8'h08
`define FCM_KEY_HI_OFS     8'h0C
`define FCM_FRAME_OFS      8'h10

`define FCM_CTRL_SWREQ_BIT 0
`define FCM_CTRL_CONN_BIT  1

`define FCM_ST_MODE_BIT    0
`define FCM_ST_BUSY_BIT    1
`define FCM_ST_CFM_BIT     2
`define FCM_ST_DROP_BIT    3
`define FCM_ST_TRIES_LSB   4
`define FCM_ST_TRIES_MSB   6

`define FCM_FRAME_FN_LSB   0
`define FCM_FRAME_FN_MSB   3
`define FCM_FRAME_MF_LSB   4
`define FCM_FRAME_MF_MSB   27

`define FCM_KEY_RST        32'h00000000
`define FCM_FN_RST         4'h0
`define FCM_MF_RST         24'h000000
`define FCM_FN_LAST        4'hF
`define FCM_IV_PAD         7'h00

`define FCM_REQ_TRIES      3'h5
`define FCM_SEG_BITS       10'h168
`define FCM_PAIR_BITS      10'h2D0
`define FCM_TAIL_BITS      10'h028

`endif

//--- rtl/fcm_pkg.sv
// types shared by the cipher mode block
package fcm_pkg;

  typedef enum logic [2:0]
  {
    FCM_TAIL_NONE,
    FCM_BEGIN_REQ,
    FCM_BEGIN_CONFIRM,
    FCM_BEGIN_GRANT,
    FCM_END_REQ,
    FCM_END_CONFIRM,
    FCM_END_GRANT
  } fcm_tail_cmd_t;

  typedef enum logic [1:0]
  {
    FCM_ST_IDLE,
    FCM_ST_REQ,
    FCM_ST_GRANT
  } fcm_state_t;

  typedef struct packed
  {
    logic          valid;
    fcm_tail_cmd_t cmd;
  } fcm_tail_t;

  typedef struct packed
  {
    logic valid;
    logic ks_bit;
    logic in_tail;
  } fcm_ks_t;

endpackage

//--- rtl/fcm_frame_counter.sv
// local frame and multiframe counters with the next initialization vector
`include "fcm_consts.svh"
module fcm_frame_counter
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        frame_start,
  input  wire logic        load,
  input  wire logic [3:0]  load_fn,
  input  wire logic [23:0] load_mf,
  output logic      [3:0]  fn,
  output logic      [23:0] mf,
  output logic      [3:0]  fn_next,
  output logic      [34:0] iv_next
);
  import fcm_pkg::*;

  logic [3:0]  fn_r;
  logic [23:0] mf_r;
  logic [23:0] mf_next;
  logic        wrap;

  assign wrap    = (fn_r == `FCM_FN_LAST);
  assign fn_next = fn_r + 4'h1;
  assign mf_next = wrap ? mf_r + 24'h000001 : mf_r;
  // frame in the low nibble, multiframe above, zero pad on top
  assign iv_next = {`FCM_IV_PAD, mf_next, fn_next};
  assign fn      = fn_r;
  assign mf      = mf_r;

  // software load lets both ends share one numbering
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fn_r <= `FCM_FN_RST;
      mf_r <= `FCM_MF_RST;
    end
    else if (clk_en && load)
    begin
      fn_r <= load_fn;
      mf_r <= load_mf;
    end
    else if (clk_en && frame_start)
    begin
      fn_r <= fn_next;
      mf_r <= mf_next;
    end
  end
endmodule

//--- rtl/fcm_ks_split.sv
// splits each 720 bit key stream run into downlink and uplink segments
`include "fcm_consts.svh"
module fcm_ks_split
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            clk_en,
  input  wire logic            restart,
  input  wire logic            ks_valid,
  input  wire logic            ks_bit,
  output fcm_pkg::fcm_ks_t     dl_ks,
  output fcm_pkg::fcm_ks_t     ul_ks
);
  import fcm_pkg::*;

  logic [9:0] idx_r;
  logic [9:0] seg_idx;
  logic       in_run;
  logic       first_half;
  fcm_ks_t    dl_r;
  fcm_ks_t    ul_r;
  fcm_ks_t    cur;

  assign in_run     = (idx_r < `FCM_PAIR_BITS);
  assign first_half = (idx_r < `FCM_SEG_BITS);
  assign seg_idx    = first_half ? idx_r : idx_r - `FCM_SEG_BITS;
  // first 40 bits of each segment belong to the control tail
  assign cur        = '{valid: ks_valid & in_run, ks_bit: ks_bit,
                        in_tail: (seg_idx < `FCM_TAIL_BITS)};
  assign dl_ks      = dl_r;
  assign ul_ks      = ul_r;

  // first half feeds downlink, second half uplink
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_r <= `FCM_PAIR_BITS;
      dl_r  <= '0;
      ul_r  <= '0;
    end
    else if (clk_en)
    begin
      dl_r <= first_half ? cur : '0;
      ul_r <= first_half ? '0 : cur;
      if (restart)
        idx_r <= 10'h000;
      else if (ks_valid && in_run)
        idx_r <= idx_r + 10'h001;
    end
  end
endmodule

//--- rtl/fcm_pt_cipher_ctrl.sv
// portable terminal cipher mode control with apb registers
//
// How it works
// - connection starts clear; mode flips only at handshake frames, then holds
// - same 64 bit key loaded into generator, bit 0 least significant
// - vector: frame in bits 0-3, multiframe 4-27, zeros 28-34
// - generator reloaded every encrypted frame with that frame's number
// - 720 bits per frame: first 360 downlink, last 360 uplink
// - here: decrypt receive with downlink, encrypt transmit with uplink
// - mode messages exchanged only over a duplex bearer; only the first request checks it
// - we send mode messages in even frames; peer in odd frames
// - mode control tail messages are never masked
// - every mode switch is started by this end only
// - one mode drives all bearers; new bearers take current mode
// - begin request each even frame, five tries, confirm or drop
// - decrypt from begin confirm field; discard data while waiting
// - begin grant next even frame; encrypt transmit from that frame
// - end request each even frame, five tries, confirm or drop
// - end confirm field treated clear; discard data while waiting
// - end grant next even frame; transmit clear from that frame
// - 360 bit segments: 40 tail bits then payload bits
// - masking sits before crc so checks cover the masked bits
//
// Our own choices: the placing of the registers and register access over APB.
`include "fcm_consts.svh"
module fcm_pt_cipher_ctrl
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          frame_start,
  input  wire logic          duplex_bearer,
  input  fcm_pkg::fcm_tail_t rx_tail,
  input  wire logic          rx_tail_is_control,
  input  wire logic          tx_tail_is_control,
  input  wire logic          ks_valid,
  input  wire logic          ks_bit,
  output logic               ksg_load,
  output logic      [63:0]   ksg_key,
  output logic      [34:0]   ksg_iv,
  output fcm_pkg::fcm_tail_cmd_t tx_tail_cmd,
  output logic               tx_encrypt,
  output logic               rx_decrypt,
  output logic               rx_discard,
  output logic               tx_tail_mask_en,
  output logic               rx_tail_mask_en,
  output fcm_pkg::fcm_ks_t   dl_ks,
  output fcm_pkg::fcm_ks_t   ul_ks,
  output logic               conn_mode,
  output logic               cipher_switch_confirm_prim,
  output logic               link_drop_indication
);
  import fcm_pkg::*;

  // apb: setup cycle captures read data so every answer comes from a flop
  logic          setup;
  logic          wr_acc;
  logic          sel_ctrl;
  logic          sel_status;
  logic          sel_key_lo;
  logic          sel_key_hi;
  logic          sel_frame;
  logic          mapped;
  logic [31:0]   rd_mux;
  logic [31:0]   status_word;
  logic [31:0]   frame_word;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;

  logic [31:0]   key_lo_r;
  logic [31:0]   key_hi_r;
  logic          conn_r;
  logic          conn_nxt;
  logic          pend_r;
  logic          pend_nxt;
  logic          cfm_st_r;
  logic          drop_st_r;

  fcm_state_t    state_r;
  fcm_state_t    state_nxt;
  logic          mode_r;
  logic          mode_nxt;
  logic          tgt_r;
  logic          tgt_nxt;
  logic [2:0]    tries_r;
  logic [2:0]    tries_nxt;
  fcm_tail_cmd_t tx_cmd_r;
  fcm_tail_cmd_t tx_cmd_nxt;
  logic          tx_enc_r;
  logic          tx_enc_nxt;
  logic          rx_dec_r;
  logic          rx_dec_nxt;
  logic          discard_r;
  logic          discard_nxt;
  logic          cfm_pulse_nxt;
  logic          drop_pulse_nxt;
  logic          cfm_pulse_r;
  logic          drop_pulse_r;
  logic          ksg_load_r;
  logic [34:0]   ksg_iv_r;
  logic          tx_mask_r;
  logic          rx_mask_r;

  logic [3:0]    fn;
  logic [23:0]   mf;
  logic [34:0]   iv_next;
  logic          fs;
  logic          new_even;
  logic          got_cfm;
  logic          swreq_wr;
  logic          cfm_clr;
  logic          drop_clr;

  assign setup      = psel & ~penable;
  assign wr_acc     = psel & penable & pready_r & pwrite;
  assign sel_ctrl   = (paddr == `FCM_CTRL_OFS);
  assign sel_status = (paddr == `FCM_STATUS_OFS);
  assign sel_key_lo = (paddr == `FCM_KEY_LO_OFS);
  assign sel_key_hi = (paddr == `FCM_KEY_HI_OFS);
  assign sel_frame  = (paddr == `FCM_FRAME_OFS);
  assign mapped     = sel_ctrl | sel_status | sel_key_lo | sel_key_hi
                      | sel_frame;

  assign status_word = {25'h0000000, tries_r, drop_st_r, cfm_st_r,
                        (state_r != FCM_ST_IDLE), mode_r};
  assign frame_word  = {4'h0, mf, fn};
  assign rd_mux = sel_ctrl   ? {30'h00000000, conn_r, pend_r} :
                  sel_status ? status_word :
                  sel_key_lo ? key_lo_r :
                  sel_key_hi ? key_hi_r :
                  sel_frame  ? frame_word : 32'h00000000;

  assign swreq_wr = wr_acc & sel_ctrl & pwdata[`FCM_CTRL_SWREQ_BIT];
  assign cfm_clr  = wr_acc & sel_status & pwdata[`FCM_ST_CFM_BIT];
  assign drop_clr = wr_acc & sel_status & pwdata[`FCM_ST_DROP_BIT];

  // new frame is even when the frame now ending is odd
  assign fs       = frame_start;
  assign new_even = fn[0];
  // confirm must name the direction we asked
  assign got_cfm  = rx_tail.valid && (state_r == FCM_ST_REQ) &&
                    (rx_tail.cmd == (tgt_r ? FCM_BEGIN_CONFIRM
                                           : FCM_END_CONFIRM));

  fcm_frame_counter u_frame
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .clk_en      (clk_en),
    .frame_start (fs),
    .load        (wr_acc & sel_frame),
    .load_fn     (pwdata[`FCM_FRAME_FN_MSB:`FCM_FRAME_FN_LSB]),
    .load_mf     (pwdata[`FCM_FRAME_MF_MSB:`FCM_FRAME_MF_LSB]),
    .fn          (fn),
    .mf          (mf),
    .fn_next     (),
    .iv_next     (iv_next)
  );

  fcm_ks_split u_split
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .restart  (ksg_load_r),
    .ks_valid (ks_valid),
    .ks_bit   (ks_bit),
    .dl_ks    (dl_ks),
    .ul_ks    (ul_ks)
  );

  always_comb
  begin
    state_nxt      = state_r;
    mode_nxt       = mode_r;
    tgt_nxt        = tgt_r;
    tries_nxt      = tries_r;
    tx_cmd_nxt     = fs ? FCM_TAIL_NONE : tx_cmd_r;
    tx_enc_nxt     = tx_enc_r;
    rx_dec_nxt     = rx_dec_r;
    discard_nxt    = discard_r;
    pend_nxt       = pend_r | (swreq_wr & conn_r);
    conn_nxt       = (wr_acc & sel_ctrl) ? pwdata[`FCM_CTRL_CONN_BIT] : conn_r;
    cfm_pulse_nxt  = 1'b0;
    drop_pulse_nxt = 1'b0;
    case (state_r)
      FCM_ST_IDLE:
      begin
        // only this end opens a switch, and only on a duplex bearer
        if (fs && new_even && pend_r && conn_r && duplex_bearer)
        begin
          tgt_nxt     = ~mode_r;
          tx_cmd_nxt  = mode_r ? FCM_END_REQ : FCM_BEGIN_REQ;
          tries_nxt   = 3'h1;
          discard_nxt = 1'b1;
          pend_nxt    = 1'b0;
          state_nxt   = FCM_ST_REQ;
        end
      end
      FCM_ST_REQ:
      begin
        if (got_cfm)
        begin
          // confirm field itself is already read in the new mode
          rx_dec_nxt    = tgt_r;
          discard_nxt   = 1'b0;
          cfm_pulse_nxt = 1'b1;
          state_nxt     = FCM_ST_GRANT;
        end
        else if (fs && !new_even)
          rx_dec_nxt = tgt_r;
        else if (fs && tries_r == `FCM_REQ_TRIES)
        begin
          // five tries unanswered: release and report the drop
          state_nxt      = FCM_ST_IDLE;
          conn_nxt       = 1'b0;
          drop_pulse_nxt = 1'b1;
        end
        else if (fs)
        begin
          tx_cmd_nxt = tgt_r ? FCM_BEGIN_REQ : FCM_END_REQ;
          tries_nxt  = tries_r + 3'h1;
        end
      end
      FCM_ST_GRANT:
      begin
        if (fs && new_even)
        begin
          tx_cmd_nxt = tgt_r ? FCM_BEGIN_GRANT : FCM_END_GRANT;
          tx_enc_nxt = tgt_r;
          mode_nxt   = tgt_r;
          state_nxt  = FCM_ST_IDLE;
        end
      end
      default:
        state_nxt = FCM_ST_IDLE;
    endcase
    // a released connection restarts clear
    if (!conn_nxt)
    begin
      state_nxt   = FCM_ST_IDLE;
      mode_nxt    = 1'b0;
      tx_enc_nxt  = 1'b0;
      rx_dec_nxt  = 1'b0;
      discard_nxt = 1'b0;
      pend_nxt    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      key_lo_r  <= `FCM_KEY_RST;
      key_hi_r  <= `FCM_KEY_RST;
      cfm_st_r  <= 1'b0;
      drop_st_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_r  <= setup;
      prdata_r  <= setup ? rd_mux : 32'h00000000;
      pslverr_r <= setup & ~mapped;
      if (wr_acc && sel_key_lo)
        key_lo_r <= pwdata;
      if (wr_acc && sel_key_hi)
        key_hi_r <= pwdata;
      // hardware set wins over a same-cycle software clear
      cfm_st_r  <= cfm_pulse_nxt | (cfm_st_r & ~cfm_clr);
      drop_st_r <= drop_pulse_nxt | (drop_st_r & ~drop_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r      <= FCM_ST_IDLE;
      mode_r       <= 1'b0;
      tgt_r        <= 1'b0;
      tries_r      <= 3'h0;
      tx_cmd_r     <= FCM_TAIL_NONE;
      tx_enc_r     <= 1'b0;
      rx_dec_r     <= 1'b0;
      discard_r    <= 1'b0;
      pend_r       <= 1'b0;
      conn_r       <= 1'b0;
      cfm_pulse_r  <= 1'b0;
      drop_pulse_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r      <= state_nxt;
      mode_r       <= mode_nxt;
      tgt_r        <= tgt_nxt;
      tries_r      <= tries_nxt;
      tx_cmd_r     <= tx_cmd_nxt;
      tx_enc_r     <= tx_enc_nxt;
      rx_dec_r     <= rx_dec_nxt;
      discard_r    <= discard_nxt;
      pend_r       <= pend_nxt;
      conn_r       <= conn_nxt;
      cfm_pulse_r  <= cfm_pulse_nxt;
      drop_pulse_r <= drop_pulse_nxt;
    end
  end

  // generator reload and masks; masks lag the inputs one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ksg_load_r <= 1'b0;
      ksg_iv_r   <= 35'h000000000;
      tx_mask_r  <= 1'b0;
      rx_mask_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      // reload per frame with its own number while any direction ciphers or a mode switch is under way
      ksg_load_r <= fs & (tx_enc_nxt | rx_dec_nxt | (state_nxt != FCM_ST_IDLE));
      if (fs)
        ksg_iv_r <= iv_next;
      // mode messages ride clear; masks sit ahead of crc
      tx_mask_r  <= tx_enc_r & tx_tail_is_control & (tx_cmd_r == FCM_TAIL_NONE);
      rx_mask_r  <= rx_dec_r & rx_tail_is_control & ~rx_tail.valid;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign ksg_load        = ksg_load_r;
  assign ksg_key         = {key_hi_r, key_lo_r};
  assign ksg_iv          = ksg_iv_r;
  assign tx_tail_cmd     = tx_cmd_r;
  assign tx_encrypt      = tx_enc_r;
  assign rx_decrypt      = rx_dec_r;
  assign rx_discard      = discard_r;
  assign tx_tail_mask_en = tx_mask_r;
  assign rx_tail_mask_en = rx_mask_r;
  assign conn_mode       = mode_r;
  assign cipher_switch_confirm_prim = cfm_pulse_r;
  assign link_drop_indication       = drop_pulse_r;
endmodule

//--- testbench/fcm_pt_checker.sv
// assertions on the ports of the portable terminal cipher mode control
module fcm_pt_checker
  import fcm_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             frame_start,
  input wire logic             duplex_bearer,
  input fcm_pkg::fcm_tail_t    rx_tail,
  input wire logic             ks_valid,
  input wire logic             ksg_load,
  input fcm_pkg::fcm_tail_cmd_t tx_tail_cmd,
  input wire logic             tx_encrypt,
  input wire logic             rx_decrypt,
  input wire logic             rx_discard,
  input fcm_pkg::fcm_ks_t      dl_ks,
  input fcm_pkg::fcm_ks_t      ul_ks,
  input wire logic             conn_mode,
  input wire logic             cipher_switch_confirm_prim,
  input wire logic             link_drop_indication
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cfm_in = rx_tail.valid && (rx_tail.cmd == FCM_BEGIN_CONFIRM ||
                                  rx_tail.cmd == FCM_END_CONFIRM);
  wire cmd_on = tx_tail_cmd != FCM_TAIL_NONE;
  wire req_on = tx_tail_cmd == FCM_BEGIN_REQ || tx_tail_cmd == FCM_END_REQ;
  property p_conn_on;
    $rose(conn_mode) |-> $past(frame_start);
  endproperty
  a_conn_on: assert property (p_conn_on) else $error("mode rose off frame");
  property p_bgrant;
    tx_tail_cmd == FCM_BEGIN_GRANT |-> tx_encrypt && conn_mode;
  endproperty
  a_bgrant: assert property (p_bgrant) else $error("grant not ciphered");
  property p_egrant;
    tx_tail_cmd == FCM_END_GRANT |-> !tx_encrypt && !conn_mode;
  endproperty
  a_egrant: assert property (p_egrant) else $error("end grant ciphered");
  property p_cfm;
    cipher_switch_confirm_prim |-> $past(cfm_in) || $past(cfm_in, 2);
  endproperty
  a_cfm: assert property (p_cfm) else $error("confirm without cause");
  property p_cfm_keep;
    cipher_switch_confirm_prim |-> !rx_discard;
  endproperty
  a_cfm_keep: assert property (p_cfm_keep) else $error("discard stuck");
  property p_req;
    $rose(req_on) |-> $past(frame_start) && $past(duplex_bearer);
  endproperty
  a_req: assert property (p_req) else $error("request misplaced");
  property p_msg;
    $rose(cmd_on) |-> $past(frame_start);
  endproperty
  a_msg: assert property (p_msg) else $error("message off frame");
  property p_split;
    dl_ks.valid |-> !ul_ks.valid && $past(ks_valid);
  endproperty
  a_split: assert property (p_split) else $error("segment overlap");
  property p_drop;
    link_drop_indication |=> !conn_mode && !tx_encrypt && !rx_decrypt;
  endproperty
  a_drop: assert property (p_drop) else $error("drop left cipher on");
  property p_load;
    ksg_load |-> $past(frame_start) || $past(frame_start, 2);
  endproperty
  a_load: assert property (p_load) else $error("load off frame");
  c_cfm: cover property (cipher_switch_confirm_prim);
  c_drop: cover property (link_drop_indication);
  c_enc: cover property ($rose(tx_encrypt));
endmodule

//--- testbench/fcm_ft_model.sv
// fixed terminal model answering mode requests on the tail channel
module fcm_ft_model
  import fcm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              frame_start,
  input  fcm_pkg::fcm_tail_cmd_t tx_tail_cmd,
  input  wire logic              mute,
  input  wire logic [3:0]        delay,
  output fcm_pkg::fcm_tail_t     rx_tail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic          act_r;
  logic [3:0]    cnt_r;
  logic [3:0]    wait_r;
  fcm_tail_cmd_t rep_r;
  wire req_b = tx_tail_cmd == FCM_BEGIN_REQ;
  wire req_e = tx_tail_cmd == FCM_END_REQ;
  wire grant = tx_tail_cmd == FCM_BEGIN_GRANT || tx_tail_cmd == FCM_END_GRANT;
  // odd frames 2S+1 .. 2S+11 only; mute stands for a lost link
  wire send = frame_start && act_r && !cnt_r[0] && !mute;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      act_r   <= 1'b0;
      cnt_r   <= 4'h0;
      wait_r  <= 4'h0;
      rep_r   <= FCM_TAIL_NONE;
      rx_tail <= '0;
    end
    else
    begin
      if (!act_r && (req_b || req_e))
      begin
        act_r <= 1'b1;
        cnt_r <= 4'h0;
        rep_r <= req_b ? FCM_BEGIN_CONFIRM : FCM_END_CONFIRM;
      end
      else if (grant)
        act_r <= 1'b0;
      else if (frame_start && act_r)
      begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'hA)
          act_r <= 1'b0;
      end
      wait_r <= send ? delay : (wait_r != 4'h0 ? wait_r - 4'h1 : 4'h0);
      rx_tail.valid <= wait_r == 4'h1;
      // idle command field holds the inverse of the reply so a stale value never looks valid
      rx_tail.cmd <= wait_r == 4'h1 ? rep_r : fcm_tail_cmd_t'(~rep_r);
    end
endmodule

//--- testbench/test_frame_cipher_mode_sync.sv
// self-checking bench for the portable terminal cipher mode control
`include "fcm_consts.svh"
module test_frame_cipher_mode_sync
  import fcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          frame_start, duplex_bearer, ks_valid, ks_bit, mute, err;
  logic          ksg_load, tx_encrypt, rx_decrypt, rx_discard, conn_mode;
  logic          cfm_p, drop_p, dl_par, tx_ctl, rx_ctl, tx_mask, rx_mask;
  logic [7:0]    paddr;
  logic [3:0]    delay;
  logic [31:0]   pwdata, prdata, rd;
  logic [63:0]   ksg_key;
  logic [34:0]   ksg_iv;
  fcm_tail_t     rx_tail;
  fcm_tail_cmd_t tx_cmd;
  fcm_ks_t       dl_ks, ul_ks;
  int            failures, tests_run, cyc, cfm_n, drop_n, dl_n, ul_n, dl_t, ul_t;

  fcm_pt_cipher_ctrl DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .duplex_bearer(duplex_bearer),
    .rx_tail(rx_tail), .rx_tail_is_control(rx_ctl),
    .tx_tail_is_control(tx_ctl), .ks_valid(ks_valid), .ks_bit(ks_bit),
    .ksg_load(ksg_load), .ksg_key(ksg_key), .ksg_iv(ksg_iv),
    .tx_tail_cmd(tx_cmd), .tx_encrypt(tx_encrypt), .rx_decrypt(rx_decrypt),
    .rx_discard(rx_discard), .tx_tail_mask_en(tx_mask),
    .rx_tail_mask_en(rx_mask),
    .dl_ks(dl_ks), .ul_ks(ul_ks), .conn_mode(conn_mode),
    .cipher_switch_confirm_prim(cfm_p), .link_drop_indication(drop_p));
  fcm_ft_model u_ft (.pclk(pclk), .presetn(presetn), .frame_start(frame_start),
    .tx_tail_cmd(tx_cmd), .mute(mute), .delay(delay), .rx_tail(rx_tail));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    cfm_n += cfm_p;
    drop_n += drop_p;
    if (dl_ks.valid === 1'b1)
    begin
      dl_n++;
      dl_t += dl_ks.in_tail;
      dl_par ^= dl_ks.ks_bit;
    end
    if (ul_ks.valid === 1'b1)
    begin
      ul_n++;
      ul_t += ul_ks.in_tail;
    end
    if (cyc == 5000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: the cycle ceiling ends a hung access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following setup never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic frame();
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    repeat (15) @(posedge pclk);
  endtask

  task automatic ks_run();
    for (int i = 0; i < 722; i++)
    begin
      ks_valid <= 1'b1;
      ks_bit   <= i < 101;
      @(posedge pclk);
    end
    ks_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(1'b0, `FCM_STATUS_OFS, 32'h0);
    chk(rd, 64'h0, "status after reset");
    apb(1'b1, `FCM_KEY_LO_OFS, 32'h89ABCDEF);
    apb(1'b1, `FCM_KEY_HI_OFS, 32'h01234567);
    apb(1'b0, `FCM_KEY_HI_OFS, 32'h0);
    chk(rd, 64'h01234567, "key readback");
    apb(1'b0, 8'h20, 32'h0);
    chk({rd, err}, {32'h0, 1'b1}, "unmapped read");
    apb(1'b1, `FCM_FRAME_OFS, 32'h000ABCDE);
  endtask

  task automatic t_begin();
    // switch request is only taken once the connection is already up
    apb(1'b1, `FCM_CTRL_OFS, 32'h2);
    apb(1'b1, `FCM_CTRL_OFS, 32'h3);
    frame();
    chk(tx_cmd, FCM_TAIL_NONE, "request in odd frame");
    frame();
    chk({tx_cmd, rx_discard}, {FCM_BEGIN_REQ, 1'b1}, "begin request");
    frame();
    chk({cfm_n[3:0], rx_decrypt, rx_discard}, 6'h06, "confirm");
    frame();
    chk({tx_cmd, tx_encrypt, conn_mode}, {FCM_BEGIN_GRANT, 2'b11}, "grant");
    chk(ksg_iv, {7'h00, 24'h00ABCE, 4'h2}, "vector");
    chk(ksg_key, 64'h0123456789ABCDEF, "key order");
    chk({tx_mask, rx_mask}, 2'b01, "mode message clear");
    ks_run();
    chk({dl_n, ul_n}, {32'd360, 32'd360}, "segment sizes");
    chk({dl_t, ul_t}, {32'd40, 32'd40}, "tail bits");
    chk(dl_par, 1'b1, "downlink is first half");
    frame();
    chk({tx_cmd, ksg_iv[3:0]}, {FCM_TAIL_NONE, 4'h3}, "next vector");
    chk({tx_mask, rx_mask}, 2'b11, "control tails masked");
    apb(1'b0, `FCM_STATUS_OFS, 32'h0);
    chk(rd[3:0], 4'h5, "mode and confirm flags");
  endtask

  task automatic t_end();
    delay <= 4'h9;
    apb(1'b1, `FCM_CTRL_OFS, 32'h3);
    frame();
    chk({tx_cmd, rx_discard}, {FCM_END_REQ, 1'b1}, "end request");
    frame();
    chk({cfm_n[3:0], rx_decrypt, rx_discard}, 6'h08, "end confirm");
    frame();
    chk({tx_cmd, tx_encrypt, conn_mode}, {FCM_END_GRANT, 2'b00}, "end grant");
    chk({tx_mask, rx_mask}, 2'b00, "clear after end grant");
  endtask

  task automatic t_drop();
    int reqs;
    reqs = 0;
    mute <= 1'b1;
    duplex_bearer <= 1'b0;
    apb(1'b1, `FCM_CTRL_OFS, 32'h3);
    frame();
    frame();
    chk(tx_cmd, FCM_TAIL_NONE, "held without duplex bearer");
    duplex_bearer <= 1'b1;
    repeat (12)
    begin
      frame();
      reqs += tx_cmd === FCM_BEGIN_REQ;
    end
    chk(reqs, 64'd5, "request tries");
    chk({drop_n[3:0], conn_mode, rx_discard}, 6'h04, "link drop");
    apb(1'b0, `FCM_CTRL_OFS, 32'h0);
    chk(rd[1], 1'b0, "connection released");
    apb(1'b0, `FCM_STATUS_OFS, 32'h0);
    chk(rd[3:2], 2'b11, "drop and confirm flags");
    apb(1'b1, `FCM_STATUS_OFS, 32'hC);
    apb(1'b0, `FCM_STATUS_OFS, 32'h0);
    chk(rd[3:2], 2'b00, "flags cleared");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    frame_start = 1'b0;
    duplex_bearer = 1'b1;
    ks_valid = 1'b0;
    ks_bit = 1'b0;
    mute = 1'b0;
    delay = 4'h3;
    dl_par = 1'b0;
    tx_ctl = 1'b1;
    rx_ctl = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_begin();
    t_end();
    t_drop();
    complete_run();
  end
endmodule

bind fcm_pt_cipher_ctrl fcm_pt_checker u_chk (.pclk(pclk), .presetn(presetn),
  .frame_start(frame_start), .duplex_bearer(duplex_bearer), .rx_tail(rx_tail),
  .ks_valid(ks_valid), .ksg_load(ksg_load), .tx_tail_cmd(tx_tail_cmd),
  .tx_encrypt(tx_encrypt), .rx_decrypt(rx_decrypt), .rx_discard(rx_discard),
  .dl_ks(dl_ks), .ul_ks(ul_ks), .conn_mode(conn_mode),
  .cipher_switch_confirm_prim(cipher_switch_confirm_prim),
  .link_drop_indication(link_drop_indication));
